/* File: verilog/swwd_pkg.sv */
`default_nettype none
package swwd_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned BASE_PERIOD_MS  = 2;
   localparam int unsigned BASE_PERIOD_CYC = CLK_HZ / 1000 * BASE_PERIOD_MS;
   localparam int unsigned OPEN_PCT        = 40;
   localparam int unsigned FULL_PCT        = 100;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned TMR_W = 26;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ERR_W = 4;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned CFG_W = 8;

   // ------------------------------------------------------------
   // Configuration word layout and reset values
   // ------------------------------------------------------------
   localparam int unsigned CFG_EN_BIT  = 0;
   localparam int unsigned CFG_PER_LSB = 1;
   localparam int unsigned CFG_THR_LSB = 4;
   localparam int unsigned CFG_CHK_BIT = 7;

   localparam logic [SEL_W-1:0] PER_RST = 3'h5;
   localparam logic [SEL_W-1:0] THR_RST = 3'h3;

   // ------------------------------------------------------------
   // Error counter steps
   // ------------------------------------------------------------
   localparam logic [ERR_W-1:0] ERR_INC = 4'h2;
   localparam logic [ERR_W-1:0] ERR_DEC = 4'h1;
   localparam logic [ERR_W-1:0] ERR_MAX = 4'hF;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SWWD_OFF    = 2'h0,
      SWWD_OPEN   = 2'h1,
      SWWD_LOCKED = 2'h3
   } swwd_state_e;

   typedef enum logic {
      SWWD_REACT_LATCHED = 1'b0,
      SWWD_REACT_ERROR   = 1'b1
   } swwd_react_e;

   typedef struct packed {
      logic             en;
      logic [SEL_W-1:0] period_sel;
      logic [SEL_W-1:0] thresh_sel;
   } swwd_cfg_s;

   typedef struct packed {
      logic fail_status;
      logic wd_latched_status;
      logic err_reaction_status;
      logic device_error_flag;
      logic device_warning_flag;
   } swwd_status_s;

   function automatic logic [ERR_W-1:0] swwd_thresh(input logic [SEL_W-1:0] sel);
      logic [ERR_W-1:0] v;
      v = 4'hF;
      case (sel)
         3'h0: v = 4'h2;
         3'h1: v = 4'h4;
         3'h2: v = 4'h6;
         3'h3: v = 4'h8;
         3'h4: v = 4'hA;
         3'h5: v = 4'hC;
         3'h6: v = 4'hE;
         default: v = 4'hF;
      endcase
      return v;
   endfunction : swwd_thresh

endpackage : swwd_pkg
`default_nettype wire

/* File: verilog/swwd_clk_meter.sv */
`timescale 1ns/1ps
`default_nettype none
module swwd_clk_meter (
   input  wire logic                       clk_i,       // System clock
   input  wire logic                       reset_n_i,   // Sync reset, active low
   input  wire logic                       run_i,       // Count enable level
   input  wire logic                       capture_i,   // Valid service pulse
   input  wire logic                       restart_i,   // Restart pulse
   output logic [swwd_pkg::CNT_W-1:0]      result_o     // Stored result
);
   import swwd_pkg::*;

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] res_q, res_d;

   always_comb begin
      cnt_d = cnt_q;
      res_d = res_q;
      if (capture_i) begin
         res_d = cnt_q;
      end
      if (capture_i || restart_i) begin
         cnt_d = '0;
      end else if (run_i && (cnt_q != {CNT_W{1'b1}})) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_q <= '0;
         res_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         res_q <= res_d;
      end
   end

   assign result_o = res_q;

endmodule : swwd_clk_meter
`default_nettype wire

/* File: verilog/swwd_err_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module swwd_err_cnt (
   input  wire logic                       clk_i,       // System clock
   input  wire logic                       reset_n_i,   // Sync reset, active low
   input  wire logic                       inc_i,       // Failed service pulse
   input  wire logic                       dec_i,       // Valid service pulse
   output logic [swwd_pkg::ERR_W-1:0]      cnt_o        // Error count
);
   import swwd_pkg::*;

   logic [ERR_W-1:0] cnt_q, cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (inc_i) begin
         // Saturate so a long fault run cannot wrap back below the threshold
         cnt_d = (cnt_q > (ERR_MAX - ERR_INC)) ? ERR_MAX : cnt_q + ERR_INC;
      end else if (dec_i) begin
         cnt_d = (cnt_q == '0) ? '0 : cnt_q - ERR_DEC;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign cnt_o = cnt_q;

endmodule : swwd_err_cnt
`default_nettype wire

/* File: verilog/swwd_top.sv */
// Operation
// - Period is 2 ms shifted by a 3-bit field, up to 256 ms; 64 ms after reset.
// - Each period is 40 percent open window, then 60 percent locked window.
// - After reset supervision is off until a write sets the enable bit.
// - Latched reaction at threshold sets device error and disables all half-bridges.
// - Error reaction at threshold sets device error and its status bit, but does not disable the half-bridges.
// - Period starts open; a correct config write with the enable bit set while open is a valid service.
// - Period and failure threshold are writable in power-up and normal mode.
// - Valid service stores clock count, restarts it, error count minus one, locks.
// - Config write data must have even parity, else discarded with SPI error.
// - Locked service, bad command or missed window: reopen, error count plus two.
// - Clock counter keeps counting after failure; saturated value gets stored.
// - The first failed service sets the failure status bit.
// - At threshold run the reaction and set the latched status bit.
// - Threshold choices 2,4,6,8,10,12,14,15; 8 after reset.
// - Failure sets device warning; valid service clears it unless latched is set.
// - Clock counter measures cycles between valid services; result held till next.
// - Clearing the latched status bit restarts the clock counter.
// - Latched reaction drives error pin low and switches off all MOSFETs.
// - Error reaction drives error pin low, gate drivers left alone.
`timescale 1ns/1ps
`default_nettype none
module swwd_top #(
   parameter int unsigned BASE_PERIOD_CYC = swwd_pkg::BASE_PERIOD_CYC  // Cycles in the 2 ms base period
) (
   input  wire logic                         clk_i,           // 100 MHz clock
   input  wire logic                         reset_n_i,       // Sync reset, active low
   input  wire logic                         cfg_wr_i,        // Config register write pulse
   input  wire logic [swwd_pkg::CFG_W-1:0]   cfg_data_i,      // Config write data
   input  wire logic                         bad_cmd_i,       // Invalid watchdog command pulse
   input  wire swwd_pkg::swwd_react_e        react_sel_i,     // Failure reaction choice
   input  wire logic                         clr_latched_i,   // Clear latched status pulse
   input  wire logic                         clr_fail_i,      // Clear failure status pulse
   output swwd_pkg::swwd_status_s            status_o,        // Status bits and flags
   output logic                              err_n_o,         // Error pin, active low
   output logic                              bridge_off_o,    // Disable all half-bridges
   output logic                              spi_err_o,       // Parity error pulse
   output logic                              service_ok_o,    // Valid service pulse
   output logic                              window_open_o,   // Open window level
   output swwd_pkg::swwd_cfg_s               cfg_o,           // Active configuration
   output logic [swwd_pkg::ERR_W-1:0]        err_cnt_o,       // Error counter
   output logic [swwd_pkg::CNT_W-1:0]        clk_result_o     // Stored clock count
);
   import swwd_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   swwd_state_e      state_q, state_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   swwd_cfg_s        cfg_q, cfg_d;
   swwd_status_s     sts_q, sts_d;
   logic             err_n_q, err_n_d;
   logic             brg_q, brg_d;
   logic             spi_err_q, spi_err_d;
   logic             svc_q, svc_d;
   logic             open_q, open_d;

   logic [31:0]      period_w;
   logic [31:0]      open_w;
   logic [TMR_W-1:0] period_cyc;
   logic [TMR_W-1:0] open_cyc;
   logic [31:0]      wr_open_w;
   logic [TMR_W-1:0] wr_open_cyc;

   logic             parity_ok;
   logic             good_wr;
   logic             svc_evt;
   logic             fail_evt;
   logic             reach_evt;
   logic [ERR_W:0]   err_next;
   logic [ERR_W-1:0] thresh;
   swwd_cfg_s        wr_cfg;

   // ----------------------------------------------------------------
   // Window lengths
   // ----------------------------------------------------------------
   // Widened to 32 bits so the percentage product cannot overflow
   always_comb begin
      period_w   = BASE_PERIOD_CYC << cfg_q.period_sel;
      open_w     = period_w * OPEN_PCT / FULL_PCT;
      period_cyc = period_w[TMR_W-1:0];
      open_cyc   = open_w[TMR_W-1:0];
      // A servicing write may change the period, so the lock must follow the new one
      wr_open_w   = (BASE_PERIOD_CYC << wr_cfg.period_sel) * OPEN_PCT / FULL_PCT;
      wr_open_cyc = wr_open_w[TMR_W-1:0];
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   always_comb begin
      parity_ok = ~(^cfg_data_i);
      good_wr   = cfg_wr_i && parity_ok;
      wr_cfg.en         = cfg_data_i[CFG_EN_BIT];
      wr_cfg.period_sel = cfg_data_i[CFG_PER_LSB +: SEL_W];
      wr_cfg.thresh_sel = cfg_data_i[CFG_THR_LSB +: SEL_W];
      thresh    = swwd_thresh(cfg_q.thresh_sel);
   end

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   // Writes are accepted in any state; only parity gates them
   always_comb begin
      cfg_d = cfg_q;
      if (good_wr) begin
         cfg_d = wr_cfg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cfg_q.en         <= 1'b0;
         cfg_q.period_sel <= PER_RST;
         cfg_q.thresh_sel <= THR_RST;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // ----------------------------------------------------------------
   // Window state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_d  = state_q;
      tmr_d    = tmr_q;
      svc_evt  = 1'b0;
      fail_evt = 1'b0;
      case (state_q)
         SWWD_OFF: begin
            tmr_d = '0;
            if (good_wr && wr_cfg.en) begin
               state_d = SWWD_OPEN;
            end
         end
         SWWD_OPEN: begin
            tmr_d = tmr_q + 1'b1;
            if (good_wr && wr_cfg.en) begin
               svc_evt = 1'b1;
               state_d = SWWD_LOCKED;
               tmr_d   = wr_open_cyc;
            end else if (bad_cmd_i || (tmr_q + 1'b1 >= open_cyc)) begin
               fail_evt = 1'b1;
               tmr_d    = '0;
            end
         end
         SWWD_LOCKED: begin
            tmr_d = tmr_q + 1'b1;
            if ((good_wr && wr_cfg.en) || bad_cmd_i) begin
               fail_evt = 1'b1;
               state_d  = SWWD_OPEN;
               tmr_d    = '0;
            end else if (tmr_q + 1'b1 >= period_cyc) begin
               state_d = SWWD_OPEN;
               tmr_d   = '0;
            end
         end
         default: begin
            state_d = SWWD_OFF;
            tmr_d   = '0;
         end
      endcase
      // A write that clears the enable bit stops supervision at once
      if (good_wr && !wr_cfg.en) begin
         state_d  = SWWD_OFF;
         tmr_d    = '0;
         svc_evt  = 1'b0;
         fail_evt = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_q <= SWWD_OFF;
         tmr_q   <= '0;
      end else begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
      end
   end

   // ----------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------
   swwd_err_cnt u_err_cnt (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .inc_i     (fail_evt),
      .dec_i     (svc_evt),
      .cnt_o     (err_cnt_o)
   );

   swwd_clk_meter u_clk_meter (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .run_i     (state_q != SWWD_OFF),
      .capture_i (svc_evt),
      .restart_i (clr_latched_i),
      .result_o  (clk_result_o)
   );

   // Threshold test on the value the counter is about to take
   always_comb begin
      err_next  = {1'b0, err_cnt_o} + {1'b0, ERR_INC};
      if (err_next > {1'b0, ERR_MAX}) begin
         err_next = {1'b0, ERR_MAX};
      end
      reach_evt = fail_evt && (err_next >= {1'b0, thresh});
   end

   // ----------------------------------------------------------------
   // Status, flags and reaction
   // ----------------------------------------------------------------
   // Software clears apply first so that a same-cycle event still sets
   always_comb begin
      sts_d     = sts_q;
      brg_d     = brg_q;
      spi_err_d = cfg_wr_i && !parity_ok;
      svc_d     = svc_evt;
      open_d    = (state_d == SWWD_OPEN);
      if (clr_fail_i) begin
         sts_d.fail_status = 1'b0;
      end
      if (clr_latched_i) begin
         sts_d.wd_latched_status   = 1'b0;
         sts_d.err_reaction_status = 1'b0;
         sts_d.device_error_flag   = 1'b0;
         brg_d                     = 1'b0;
      end
      if (fail_evt) begin
         sts_d.fail_status         = 1'b1;
         sts_d.device_warning_flag = 1'b1;
      end else if (svc_evt && !sts_q.wd_latched_status) begin
         sts_d.device_warning_flag = 1'b0;
      end
      if (reach_evt) begin
         sts_d.wd_latched_status = 1'b1;
         sts_d.device_error_flag = 1'b1;
         if (react_sel_i == SWWD_REACT_LATCHED) begin
            brg_d = 1'b1;
         end else begin
            sts_d.err_reaction_status = 1'b1;
         end
      end
      // Pin follows the device error flag for both reactions
      err_n_d = !sts_d.device_error_flag;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sts_q     <= '0;
         brg_q     <= 1'b0;
         err_n_q   <= 1'b1;
         spi_err_q <= 1'b0;
         svc_q     <= 1'b0;
         open_q    <= 1'b0;
      end else begin
         sts_q     <= sts_d;
         brg_q     <= brg_d;
         err_n_q   <= err_n_d;
         spi_err_q <= spi_err_d;
         svc_q     <= svc_d;
         open_q    <= open_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign status_o      = sts_q;
   assign err_n_o       = err_n_q;
   assign bridge_off_o  = brg_q;
   assign spi_err_o     = spi_err_q;
   assign service_ok_o  = svc_q;
   assign window_open_o = open_q;
   assign cfg_o         = cfg_q;

endmodule : swwd_top
`default_nettype wire

/* File: dv/swwd_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module swwd_top_chk
   import swwd_pkg::*;
#(
   parameter int unsigned BASE_PERIOD_CYC = 100  // Base period in cycles
) (
   input wire logic                       clk_i,          // Clock
   input wire logic                       reset_n_i,      // Sync reset
   input wire logic                       cfg_wr_i,       // Config write
   input wire logic [swwd_pkg::CFG_W-1:0] cfg_data_i,     // Write data
   input wire logic                       bad_cmd_i,      // Bad command
   input wire swwd_pkg::swwd_react_e      react_sel_i,    // Reaction choice
   input wire logic                       clr_latched_i,  // Clear latched
   input wire logic                       clr_fail_i,     // Clear failure
   input wire swwd_pkg::swwd_status_s     status_o,       // Status
   input wire logic                       err_n_o,        // Error pin
   input wire logic                       bridge_off_o,   // Bridges off
   input wire logic                       spi_err_o,      // Parity error
   input wire logic                       service_ok_o,   // Good service
   input wire logic                       window_open_o,  // Open window
   input wire swwd_pkg::swwd_cfg_s        cfg_o,          // Active config
   input wire logic [swwd_pkg::ERR_W-1:0] err_cnt_o,      // Error count
   input wire logic [swwd_pkg::CNT_W-1:0] clk_result_o    // Stored count
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [ERR_W-1:0] thr;
   assign thr = (cfg_o.thresh_sel == 3'h7) ? 4'hF : {cfg_o.thresh_sel, 1'b0} + 4'h2;
   // ------------------------------------------
   // Properties
   // ------------------------------------------
   property p_svc_lock; service_ok_o |-> !window_open_o ##1 !service_ok_o; endproperty
   a_svc_lock: assert property (p_svc_lock) else $error("service did not lock");
   property p_dec; service_ok_o |-> err_cnt_o == (($past(err_cnt_o) == 4'h0) ? 4'h0 : $past(err_cnt_o) - 4'h1);
   endproperty
   a_dec: assert property (p_dec) else $error("bad decrement");
   property p_inc;
      $changed(err_cnt_o) && !service_ok_o |-> status_o.device_warning_flag && status_o.fail_status &&
         err_cnt_o == (($past(err_cnt_o) > 4'hD) ? 4'hF : $past(err_cnt_o) + 4'h2);
   endproperty
   a_inc: assert property (p_inc) else $error("bad failure step");
   property p_pin; err_n_o != status_o.device_error_flag; endproperty
   a_pin: assert property (p_pin) else $error("error pin mismatch");
   property p_bridge; $rose(bridge_off_o) |-> $past(react_sel_i) == SWWD_REACT_LATCHED && status_o.device_error_flag;
   endproperty
   a_bridge: assert property (p_bridge) else $error("bridge off wrongly");
   property p_react; $rose(status_o.err_reaction_status) |-> $past(react_sel_i) == SWWD_REACT_ERROR && !err_n_o;
   endproperty
   a_react: assert property (p_react) else $error("wrong reaction");
   property p_latch; $rose(status_o.wd_latched_status) |-> err_cnt_o >= thr && status_o.device_error_flag;
   endproperty
   a_latch: assert property (p_latch) else $error("latched below threshold");
   property p_parity; spi_err_o |-> !service_ok_o && $stable(cfg_o) && $stable(err_cnt_o); endproperty
   a_parity: assert property (p_parity) else $error("bad parity write acted");
   property p_hold; !service_ok_o |-> $stable(clk_result_o); endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_warn; service_ok_o && !$past(status_o.wd_latched_status) |-> !status_o.device_warning_flag;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not cleared");
   c_svc: cover property (service_ok_o);
   c_par: cover property (spi_err_o);
   c_off: cover property ($rose(bridge_off_o));
   c_err: cover property ($rose(status_o.err_reaction_status));
endmodule : swwd_top_chk
bind swwd_top swwd_top_chk #(.BASE_PERIOD_CYC(BASE_PERIOD_CYC)) i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .cfg_wr_i(cfg_wr_i), .cfg_data_i(cfg_data_i), .bad_cmd_i(bad_cmd_i), .react_sel_i(react_sel_i),
   .clr_latched_i(clr_latched_i), .clr_fail_i(clr_fail_i), .status_o(status_o), .err_n_o(err_n_o),
   .bridge_off_o(bridge_off_o), .spi_err_o(spi_err_o), .service_ok_o(service_ok_o),
   .window_open_o(window_open_o), .cfg_o(cfg_o), .err_cnt_o(err_cnt_o), .clk_result_o(clk_result_o));
`default_nettype wire

/* File: dv/swwd_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swwd_mcu_model (
   input  wire logic       clk_i,       // Clock
   input  wire logic       req_i,       // Send one config frame
   input  wire logic [6:0] payload_i,   // Data bits below the checksum
   input  wire logic       flip_i,      // Corrupt the checksum on purpose
   output logic            cfg_wr_o,    // Config write pulse
   output logic [7:0]      cfg_data_o   // Config write data
);
   initial begin
      cfg_wr_o = 1'b0;
      cfg_data_o = 8'h00;
   end
   // Idle data toggles so a stale word is never mistaken for a frame
   always @(posedge clk_i) begin
      cfg_wr_o <= req_i;
      if (req_i) begin
         cfg_data_o <= {(^payload_i) ^ flip_i, payload_i};
      end else begin
         cfg_data_o <= ~cfg_data_o;
      end
   end
endmodule : swwd_mcu_model
`default_nettype wire

/* File: dv/spi_window_watchdog_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_window_watchdog_test;
   import swwd_pkg::*;
   localparam int unsigned BASE = 100;
   logic             clk_i, reset_n_i, req, flip, bad_cmd, clr_lat, clr_fail, wr, err_n, boff, spi_err, svc, wopen;
   logic [6:0]       payload;
   logic [CFG_W-1:0] wdata;
   swwd_react_e      react;
   swwd_status_s     st;
   swwd_cfg_s        cfg;
   logic [ERR_W-1:0] ecnt;
   logic [CNT_W-1:0] res, r1;
   logic [31:0]      seed = 32'h914F;
   int               n_mismatch = 0, total_checks = 0, n, g, e;
   swwd_mcu_model i_mcu (.clk_i(clk_i), .req_i(req), .payload_i(payload), .flip_i(flip), .cfg_wr_o(wr),
      .cfg_data_o(wdata));
   swwd_top #(.BASE_PERIOD_CYC(BASE)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_wr_i(wr),
      .cfg_data_i(wdata), .bad_cmd_i(bad_cmd), .react_sel_i(react), .clr_latched_i(clr_lat),
      .clr_fail_i(clr_fail), .status_o(st), .err_n_o(err_n), .bridge_off_o(boff), .spi_err_o(spi_err),
      .service_ok_o(svc), .window_open_o(wopen), .cfg_o(cfg), .err_cnt_o(ecnt), .clk_result_o(res));
   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : tick
   // Frame reaches the block two edges later; outputs are read just after
   task automatic send(input logic [2:0] per, input logic [2:0] thr, input logic f);
      @(posedge clk_i);
      req <= 1'b1;
      payload <= {thr, per, 1'b1};
      flip <= f;
      @(posedge clk_i);
      req <= 1'b0;
      tick(1);
   endtask : send
   // Mask order is bad command, clear latched, clear failure
   task automatic pulse(input logic [2:0] m);
      @(posedge clk_i);
      {bad_cmd, clr_lat, clr_fail} <= m;
      @(posedge clk_i);
      {bad_cmd, clr_lat, clr_fail} <= 3'h0;
      #1;
   endtask : pulse
   task automatic do_reset();
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      tick(1);
   endtask : do_reset
   task automatic wait_open(output int k);
      k = 0;
      while (wopen !== 1'b1 && k < 3000) begin
         tick(1);
         k++;
      end
   endtask : wait_open
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #900000;
      n_mismatch++;
      conclude();
   end
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      {reset_n_i, req, flip, bad_cmd, clr_lat, clr_fail, payload} = '0;
      react = SWWD_REACT_LATCHED;
      do_reset();
      chk(st, 0);
      chk({err_n, boff, ecnt, res}, {1'b1, 1'b0, 4'h0, 16'h0});
      chk(cfg, {1'b0, 3'h5, 3'h3});
      pulse(3'h4);
      chk(ecnt, 0);
      send(3'h0, 3'h3, 1'b0);
      chk({wopen, cfg}, {1'b1, 1'b1, 3'h0, 3'h3});
      send(3'h0, 3'h3, 1'b0);
      chk({svc, wopen, ecnt}, {1'b1, 1'b0, 4'h0});
      send(3'h0, 3'h3, 1'b0);
      chk({ecnt, st.fail_status, st.device_warning_flag, wopen}, {4'h2, 3'b111});
      send(3'h0, 3'h3, 1'b0);
      chk({svc, ecnt, st.device_warning_flag}, {1'b1, 4'h1, 1'b0});
      send(3'h2, 3'h3, 1'b1);
      chk({spi_err, svc, cfg, ecnt}, {2'b10, 1'b1, 3'h0, 3'h3, 4'h1});
      for (int s = 0; s < 3; s++) begin
         wait_open(n);
         send(s[2:0], 3'h3, 1'b0);
         wait_open(n);
         chk(n, (BASE << s) * 60 / 100);
      end
      send(3'h0, 3'h3, 1'b0);
      tick(64);
      send(3'h0, 3'h3, 1'b0);
      r1 = res;
      g = 64 + (rnd() % 25);
      tick(g);
      send(3'h0, 3'h3, 1'b0);
      chk(res - r1, g - 64);
      r1 = res;
      tick(30);
      pulse(3'h2);
      tick(40);
      chk(res, r1);
      send(3'h0, 3'h3, 1'b0);
      chk(res < r1 - 16'd20, 1);
      for (int s = 0; s < 8; s++) begin
         do_reset();
         react <= swwd_react_e'(s[0] ^ rnd() % 2);
         send(3'h0, s[2:0], 1'b0);
         e = (s == 7) ? 15 : 2 * s + 2;
         repeat ((e + 1) / 2 - 1) pulse(3'h4);
         chk(st.wd_latched_status, 0);
         pulse(3'h4);
         chk({st.wd_latched_status, st.device_error_flag, err_n}, 3'b110);
         chk({boff, st.err_reaction_status}, {react == SWWD_REACT_LATCHED, react == SWWD_REACT_ERROR});
      end
      wait_open(n);
      send(3'h0, 3'h7, 1'b0);
      chk({svc, st.device_warning_flag}, 2'b11);
      pulse(3'h2);
      tick(1);
      chk({st.wd_latched_status, boff, err_n}, 3'b001);
      pulse(3'h1);
      tick(1);
      chk(st.fail_status, 0);
      do_reset();
      send(3'h0, 3'h3, 1'b0);
      tick(66000);
      wait_open(n);
      send(3'h0, 3'h3, 1'b0);
      // The closing service itself takes one off the saturated error count
      chk({res, ecnt}, {16'hFFFF, 4'hE});
      conclude();
   end
endmodule : spi_window_watchdog_test
`default_nettype wire
